// ### scc_clock_ctl.sv
/*
  system clock source control: holds the oscillator, pll and main-clock
  control bits, decodes pin modes, runs the low-speed oscillator gating and
  steers the cpu clock tick from the chosen source.
  assumes source clocks arrive as one-cycle ticks synchronous to mclk and
  that software keeps its own ordering duties (both sources alive before a
  switch, usb stopped before leaving the pll, no pll start on subclock).
*/
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - with x1 select at 0, selector output becomes the main clock
// - bits 7,6 pick x1 pins: 01 resonator, 11 external, 00 port
// - bits 5,4 pick xt1 pins: 01 resonator, 11 external, 00 port
// - xt1 drive code 10 selects ultra-low-power oscillation
// - run status bit 0 starts or stops the fast on-chip oscillator
// - fast on-chip oscillator runs after reset without software action
// - low-speed oscillator feeds only watchdog, rtc and interval timer
// - low-speed oscillator runs when watchdog option or rtc select set
// - it stops only with watchdog on, select 0, no standby run, standby
// - while watchdog runs the low-speed oscillator keeps running otherwise
// - pll multiplies high-speed clock, run bit 0 turns it on and off
// - osc mode bits 5,4 at 01 enable the 32.768 kHz xt1 oscillator unless run status bit 6 is set
// - x1 oscillator takes a 1 to 20 MHz resonator
// - selector value 0 picks the fast on-chip oscillator
// - divide field 00, 01, 10 divides selector output by 2, 4, 8
// - x1 select set makes x1 the cpu clock unless the subclock cpu bit 6 is also set
module scc_clock_ctl (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // register writes, one strobe per register, shared data
  input  wire logic [7:0]       wr_data,
  input  wire logic             wr_osc_mode,
  input  wire logic             wr_osc_run,
  input  wire logic             wr_sys_clk,
  input  wire logic             wr_pll,
  input  wire logic             wr_main_src,
  input  wire logic             wr_supply,
  // option and power state
  input  wire logic             watchdog_run_option,
  input  wire logic             watchdog_standby_run,
  input  wire logic             standby_active,
  // source clock ticks
  input  wire logic             fast_osc_tick,
  input  wire logic             pll_tick,
  input  wire logic             x1_tick,
  input  wire logic             xt1_tick,
  // register read-back
  output scc_pkg::scc_regs_t    regs_rd,
  // oscillator control
  output scc_pkg::scc_osc_ctl_t osc_ctl,
  output scc_pkg::scc_lsosc_t   lsosc,
  // clock outputs
  output scc_pkg::scc_cpu_src_t cpu_src,
  output logic                  cpu_clk_tick,
  output logic                  usb_src_tick
);
  import scc_pkg::*;

  scc_regs_t    regs_ff;
  scc_regs_t    nxt_regs;
  scc_osc_ctl_t osc_ff;
  scc_osc_ctl_t nxt_osc;
  scc_lsosc_t   ls_ff;
  scc_lsosc_t   nxt_ls;
  scc_cpu_src_t src_ff;
  scc_cpu_src_t nxt_src;
  logic         cpu_tick_ff;
  logic         nxt_cpu_tick;
  logic         usb_tick_ff;
  logic         nxt_usb_tick;
  logic         sel_tick;
  logic         div_tick;

  // register writes; reserved bits are masked so they stay zero
  always_comb begin
    nxt_regs = regs_ff;
    if (wr_osc_mode) begin
      nxt_regs.osc_mode_control = wr_data & SCC_MODE_MASK;
    end
    if (wr_osc_run) begin
      nxt_regs.osc_run_status_control = wr_data & SCC_RUN_MASK;
    end
    if (wr_sys_clk) begin
      nxt_regs.system_clock_control = wr_data & SCC_SYS_MASK;
    end
    if (wr_pll) begin
      nxt_regs.pll_control = wr_data & SCC_PLL_MASK;
    end
    if (wr_main_src) begin
      // upper bits are dropped even if software breaks the zero-write habit
      nxt_regs.main_source_control[SCC_SRC_SEL_BIT] = wr_data[SCC_SRC_SEL_BIT];
      // reserved divide code 11 leaves the running ratio alone
      if (wr_data[SCC_DIV_HI_BIT:SCC_DIV_LO_BIT] != SCC_DIVBAD) begin
        nxt_regs.main_source_control[SCC_DIV_HI_BIT:SCC_DIV_LO_BIT] =
          wr_data[SCC_DIV_HI_BIT:SCC_DIV_LO_BIT];
      end
    end
    if (wr_supply) begin
      nxt_regs.subsystem_supply_control = wr_data & SCC_SUP_MASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      regs_ff.osc_mode_control         <= SCC_MODE_RST;
      regs_ff.osc_run_status_control   <= SCC_RUN_RST;
      regs_ff.system_clock_control     <= SCC_SYS_RST;
      regs_ff.pll_control              <= SCC_PLL_RST;
      regs_ff.main_source_control      <= SCC_MAIN_RST;
      regs_ff.subsystem_supply_control <= SCC_SUP_RST;
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  // pin modes and oscillator enables from the stored bits
  always_comb begin
    logic [1:0] x1_pat;
    logic [1:0] xt1_pat;
    x1_pat  = {regs_ff.osc_mode_control[SCC_X1_EXT_BIT],
               regs_ff.osc_mode_control[SCC_X1_PIN_BIT]};
    xt1_pat = {regs_ff.osc_mode_control[SCC_XT1_EXT_BIT],
               regs_ff.osc_mode_control[SCC_XT1_PIN_BIT]};
    nxt_osc = osc_ff;
    // pattern 10 has no meaning, so the pins fall back to port mode
    case (x1_pat)
      2'h1:    nxt_osc.x1_mode = SCC_PIN_RESONATOR;
      2'h3:    nxt_osc.x1_mode = SCC_PIN_EXTERNAL;
      default: nxt_osc.x1_mode = SCC_PIN_PORT;
    endcase
    case (xt1_pat)
      2'h1:    nxt_osc.xt1_mode = SCC_PIN_RESONATOR;
      2'h3:    nxt_osc.xt1_mode = SCC_PIN_EXTERNAL;
      default: nxt_osc.xt1_mode = SCC_PIN_PORT;
    endcase
    case ({regs_ff.osc_mode_control[SCC_XT1_DRV_HI],
           regs_ff.osc_mode_control[SCC_XT1_DRV_LO]})
      2'h0:    nxt_osc.xt1_drive = SCC_DRV_LOW_POWER;
      2'h1:    nxt_osc.xt1_drive = SCC_DRV_NORMAL;
      2'h2:    nxt_osc.xt1_drive = SCC_DRV_ULTRA_LOW;
      default: nxt_osc.xt1_drive = SCC_DRV_RESERVED;
    endcase
    nxt_osc.x1_high_gain = regs_ff.osc_mode_control[SCC_X1_GAIN_BIT];
    // x1 amplifier only runs in resonator mode, sized for 1 to 20 MHz parts
    nxt_osc.x1_osc_run = (x1_pat == 2'h1) &
                         ~regs_ff.osc_run_status_control[SCC_X1_STOP_BIT];
    // the 32.768 kHz amplifier needs bit 4 set, bit 5 clear and the stop bit clear
    nxt_osc.xt1_osc_run = regs_ff.osc_mode_control[SCC_XT1_PIN_BIT] &
                          ~regs_ff.osc_mode_control[SCC_XT1_EXT_BIT] &
                          ~regs_ff.osc_run_status_control[SCC_XT1_STOP_BIT];
    nxt_osc.fast_osc_run =
      ~regs_ff.osc_run_status_control[SCC_FAST_HALT];
    nxt_osc.pll_run      = regs_ff.pll_control[SCC_PLL_RUN_BIT];
    nxt_osc.pll_mult_hi  = regs_ff.pll_control[SCC_PLL_MUL_BIT];
    nxt_osc.pll_ref_div2 = regs_ff.pll_control[SCC_PLL_RDIV_BIT];
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      osc_ff.x1_mode      <= SCC_PIN_PORT;
      osc_ff.xt1_mode     <= SCC_PIN_PORT;
      osc_ff.xt1_drive    <= SCC_DRV_LOW_POWER;
      osc_ff.x1_high_gain <= 1'b0;
      osc_ff.x1_osc_run   <= 1'b0;
      osc_ff.xt1_osc_run  <= 1'b0;
      osc_ff.fast_osc_run <= 1'b1;
      osc_ff.pll_run      <= 1'b0;
      osc_ff.pll_mult_hi  <= 1'b0;
      osc_ff.pll_ref_div2 <= 1'b0;
    end else begin
      osc_ff <= nxt_osc;
    end
  end

  // low-speed oscillator: a hung program cannot stop it while the watchdog
  // runs, only the standby condition with no rtc use can
  always_comb begin
    logic rtc_sel;
    logic want;
    logic sleep_stop;
    rtc_sel    = regs_ff.subsystem_supply_control[SCC_RTC_CK_BIT];
    want       = watchdog_run_option | rtc_sel;
    sleep_stop = watchdog_run_option & ~rtc_sel &
                 ~watchdog_standby_run & standby_active;
    nxt_ls.run     = want & ~sleep_stop;
    // only these three consumers are ever fed; no cpu path exists
    nxt_ls.to_wdt  = nxt_ls.run & watchdog_run_option;
    nxt_ls.to_rtc  = nxt_ls.run & rtc_sel;
    nxt_ls.to_itmr = nxt_ls.run & rtc_sel;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ls_ff <= '0;
    end else begin
      ls_ff <= nxt_ls;
    end
  end

  // selector between pll and fast oscillator; both are assumed live
  // when software flips it, so no glitch-free handover is attempted
  assign sel_tick = regs_ff.main_source_control[SCC_SRC_SEL_BIT] ?
                    pll_tick : fast_osc_tick;

  scc_tick_div #(
    .CNT_W (3)
  ) u_main_div (
    .mclk     (mclk),
    .rst      (rst),
    .ratio    (regs_ff.main_source_control[SCC_DIV_HI_BIT:SCC_DIV_LO_BIT]),
    .src_tick (sel_tick),
    .div_tick (div_tick)
  );

  // cpu clock steering; the low-speed oscillator is never a candidate
  always_comb begin
    nxt_src      = SCC_CPU_ONCHIP;
    nxt_cpu_tick = 1'b0;
    if (regs_ff.system_clock_control[SCC_SUB_CPU_BIT]) begin
      nxt_src      = SCC_CPU_SUB;
      nxt_cpu_tick = xt1_tick;
    end else if (regs_ff.system_clock_control[SCC_X1_SEL_BIT]) begin
      nxt_src      = SCC_CPU_X1;
      nxt_cpu_tick = x1_tick;
    end else begin
      nxt_src      = regs_ff.main_source_control[SCC_SRC_SEL_BIT] ?
                     SCC_CPU_PLL : SCC_CPU_ONCHIP;
      nxt_cpu_tick = div_tick;
    end
    // usb takes the undivided selector output; software picks pll for it
    nxt_usb_tick = sel_tick;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      src_ff      <= SCC_CPU_ONCHIP;
      cpu_tick_ff <= 1'b0;
      usb_tick_ff <= 1'b0;
    end else begin
      src_ff      <= nxt_src;
      cpu_tick_ff <= nxt_cpu_tick;
      usb_tick_ff <= nxt_usb_tick;
    end
  end

  // outputs straight from flip-flops
  assign regs_rd      = regs_ff;
  assign osc_ctl      = osc_ff;
  assign lsosc        = ls_ff;
  assign cpu_src      = src_ff;
  assign cpu_clk_tick = cpu_tick_ff;
  assign usb_src_tick = usb_tick_ff;

endmodule
`default_nettype wire

// ### scc_clock_ctl_checker.sv
/*
  port assertions for scc_clock_ctl.
  assumes it is bound into scc_clock_ctl, one mclk domain.
*/
`timescale 1ns/1ns
`default_nettype none
module scc_clock_ctl_checker
  import scc_pkg::*;
(
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst,
  // inputs watched
  input  wire logic [7:0]            wr_data,
  input  wire logic                  wr_osc_mode,
  input  wire logic                  wr_osc_run,
  input  wire logic                  wr_pll,
  input  wire logic                  watchdog_run_option,
  input  wire logic                  watchdog_standby_run,
  input  wire logic                  standby_active,
  input  wire logic                  fast_osc_tick,
  input  wire logic                  pll_tick,
  // outputs watched
  input  wire scc_pkg::scc_regs_t    regs_rd,
  input  wire scc_pkg::scc_osc_ctl_t osc_ctl,
  input  wire scc_pkg::scc_lsosc_t   lsosc,
  input  wire scc_pkg::scc_cpu_src_t cpu_src,
  input  wire logic                  usb_src_tick
);
  logic         ls_want;
  logic         sel_tick;
  logic         sel;
  scc_cpu_src_t src_want;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  function automatic scc_pin_mode_t pin_of(input logic [1:0] b);
    return (b == 2'h1) ? SCC_PIN_RESONATOR : (b == 2'h3) ? SCC_PIN_EXTERNAL : SCC_PIN_PORT;
  endfunction

  // expectations from the present register and input values
  always_comb begin
    sel      = regs_rd.main_source_control[SCC_SRC_SEL_BIT];
    sel_tick = sel ? pll_tick : fast_osc_tick;
    ls_want  = (watchdog_run_option | regs_rd.subsystem_supply_control[SCC_RTC_CK_BIT])
             & ~(watchdog_run_option & ~regs_rd.subsystem_supply_control[SCC_RTC_CK_BIT]
             & ~watchdog_standby_run & standby_active);
    src_want = regs_rd.system_clock_control[SCC_SUB_CPU_BIT] ? SCC_CPU_SUB :
               regs_rd.system_clock_control[SCC_X1_SEL_BIT]  ? SCC_CPU_X1 :
               sel ? SCC_CPU_PLL : SCC_CPU_ONCHIP;
  end

  property p_fast_run;
    wr_osc_run |-> ##2 osc_ctl.fast_osc_run == !$past(wr_data[SCC_FAST_HALT], 2);
  endproperty
  a_fast_run: assert property (p_fast_run) else $error("fast osc run bit wrong");
  property p_x1_pins;
    wr_osc_mode |-> ##2 osc_ctl.x1_mode == pin_of($past(wr_data[7:6], 2));
  endproperty
  a_x1_pins: assert property (p_x1_pins) else $error("x1 pin mode wrong");
  property p_xt1_pins;
    wr_osc_mode |-> ##2 osc_ctl.xt1_mode == pin_of($past(wr_data[5:4], 2));
  endproperty
  a_xt1_pins: assert property (p_xt1_pins) else $error("xt1 pin mode wrong");
  property p_ultra;
    wr_osc_mode && wr_data[2:1] == 2'h2 |-> ##2 osc_ctl.xt1_drive == SCC_DRV_ULTRA_LOW;
  endproperty
  a_ultra: assert property (p_ultra) else $error("ultra low drive not set");
  property p_pll_run;
    wr_pll |-> ##2 osc_ctl.pll_run == $past(wr_data[SCC_PLL_RUN_BIT], 2);
  endproperty
  a_pll_run: assert property (p_pll_run) else $error("pll run bit wrong");
  property p_ls_run;
    !$past(rst) |-> lsosc.run == $past(ls_want);
  endproperty
  a_ls_run: assert property (p_ls_run) else $error("low speed osc run wrong");
  property p_ls_route;
    !$past(rst) |-> lsosc.to_wdt == (lsosc.run && $past(watchdog_run_option))
                    && lsosc.to_itmr == lsosc.to_rtc && (lsosc.to_rtc <= lsosc.run);
  endproperty
  a_ls_route: assert property (p_ls_route) else $error("low speed routing wrong");
  property p_cpu_src;
    !$past(rst) |-> cpu_src == $past(src_want);
  endproperty
  a_cpu_src: assert property (p_cpu_src) else $error("cpu source wrong");
  property p_reserved;
    (regs_rd & ~{SCC_MODE_MASK, SCC_RUN_MASK, SCC_SYS_MASK, SCC_PLL_MASK,
                 SCC_MAIN_MASK, SCC_SUP_MASK}) == 48'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit reads one");
  property p_after_reset;
    $past(rst) |-> osc_ctl.fast_osc_run && cpu_src == SCC_CPU_ONCHIP;
  endproperty
  a_after_reset: assert property (p_after_reset) else $error("not on fast osc after reset");
  property p_usb_tick;
    !$past(rst) && !$past(rst, 2) && $past(sel) == $past(sel, 2) |-> usb_src_tick == $past(sel_tick);
  endproperty
  a_usb_tick: assert property (p_usb_tick) else $error("selector tick wrong");
endmodule
`default_nettype wire

// ### scc_osc_model.sv
/*
  behavioural oscillators facing scc_clock_ctl: one tick train per source.
  assumes osc_ctl from the block under test and a free-running mclk.
*/
`timescale 1ns/1ns
`default_nettype none
module scc_osc_model
  import scc_pkg::*;
#(
  parameter int FAST_P = 2,
  parameter int PLL_P  = 3,
  parameter int X1_P   = 5, // stands in for a 1 to 20 MHz part
  parameter int XT1_P  = 7
) (
  // clock and reset
  input  wire logic            mclk,
  input  wire logic            rst,
  // run controls
  input  wire scc_osc_ctl_t    osc_ctl,
  // source ticks
  output logic                 fast_osc_tick,
  output logic                 pll_tick,
  output logic                 x1_tick,
  output logic                 xt1_tick
);
  logic [3:0][3:0] cnt_ff;
  logic [3:0][3:0] nxt_cnt;
  logic [3:0]      tick_ff;
  logic [3:0]      nxt_tick;
  logic [3:0]      run;
  logic [3:0][3:0] last;

  // a stopped source stays low instead of holding its last phase
  always_comb begin
    run[0]  = osc_ctl.fast_osc_run;
    run[1]  = osc_ctl.pll_run;
    run[2]  = osc_ctl.x1_osc_run | (osc_ctl.x1_mode == SCC_PIN_EXTERNAL);
    run[3]  = osc_ctl.xt1_osc_run | (osc_ctl.xt1_mode == SCC_PIN_EXTERNAL);
    last[0] = 4'(FAST_P - 1);
    last[1] = 4'(PLL_P - 1);
    last[2] = 4'(X1_P - 1);
    last[3] = 4'(XT1_P - 1);
    for (int i = 0; i < 4; i++) begin
      nxt_tick[i] = run[i] && (cnt_ff[i] == last[i]);
      nxt_cnt[i]  = (!run[i] || nxt_tick[i]) ? 4'h0 : cnt_ff[i] + 4'h1;
    end
  end

  // register counters and ticks
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_ff  <= '0;
      tick_ff <= 4'h0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign fast_osc_tick = tick_ff[0];
  assign pll_tick      = tick_ff[1];
  assign x1_tick       = tick_ff[2];
  assign xt1_tick      = tick_ff[3];
endmodule
`default_nettype wire

// ### scc_pkg.sv
/*
  shared constants and types for the system clock source control block:
  register bit positions, reset values, divide codes and carrier structs.
  assumes a single 125 MHz clock domain and no register bus.
*/
`default_nettype none
package scc_pkg;

  // register width and reset values
  localparam int unsigned SCC_REG_W     = 8;
  localparam logic [7:0]  SCC_MODE_RST  = 8'h00;
  localparam logic [7:0]  SCC_RUN_RST   = 8'hC0; // x1 and xt1 stopped, fast osc running
  localparam logic [7:0]  SCC_SYS_RST   = 8'h00;
  localparam logic [7:0]  SCC_PLL_RST   = 8'h00;
  localparam logic [7:0]  SCC_MAIN_RST  = 8'h00;
  localparam logic [7:0]  SCC_SUP_RST   = 8'h00;

  // writable bit masks, everything else reads zero
  localparam logic [7:0]  SCC_MODE_MASK = 8'hF7;
  localparam logic [7:0]  SCC_RUN_MASK  = 8'hC1;
  localparam logic [7:0]  SCC_SYS_MASK  = 8'h50;
  localparam logic [7:0]  SCC_PLL_MASK  = 8'h07;
  localparam logic [7:0]  SCC_MAIN_MASK = 8'h07;
  localparam logic [7:0]  SCC_SUP_MASK  = 8'h90;

  // osc_mode_control fields
  localparam int unsigned SCC_X1_EXT_BIT   = 7;
  localparam int unsigned SCC_X1_PIN_BIT   = 6;
  localparam int unsigned SCC_XT1_EXT_BIT  = 5;
  localparam int unsigned SCC_XT1_PIN_BIT  = 4;
  localparam int unsigned SCC_XT1_DRV_HI   = 2;
  localparam int unsigned SCC_XT1_DRV_LO   = 1;
  localparam int unsigned SCC_X1_GAIN_BIT  = 0;
  // osc_run_status_control fields
  localparam int unsigned SCC_X1_STOP_BIT  = 7;
  localparam int unsigned SCC_XT1_STOP_BIT = 6;
  localparam int unsigned SCC_FAST_HALT    = 0;
  // system_clock_control fields
  localparam int unsigned SCC_SUB_CPU_BIT  = 6;
  localparam int unsigned SCC_X1_SEL_BIT   = 4;
  // pll_control fields
  localparam int unsigned SCC_PLL_RDIV_BIT = 2;
  localparam int unsigned SCC_PLL_MUL_BIT  = 1;
  localparam int unsigned SCC_PLL_RUN_BIT  = 0;
  // main_source_control fields
  localparam int unsigned SCC_DIV_HI_BIT   = 2;
  localparam int unsigned SCC_DIV_LO_BIT   = 1;
  localparam int unsigned SCC_SRC_SEL_BIT  = 0;
  // subsystem_supply_control fields
  localparam int unsigned SCC_RTC_LP_BIT   = 7;
  localparam int unsigned SCC_RTC_CK_BIT   = 4;

  // divide codes of the selector output
  localparam logic [1:0]  SCC_DIV2   = 2'h0;
  localparam logic [1:0]  SCC_DIV4   = 2'h1;
  localparam logic [1:0]  SCC_DIV8   = 2'h2;
  localparam logic [1:0]  SCC_DIVBAD = 2'h3;
  localparam logic [2:0]  SCC_CNT_MAX2 = 3'h1;
  localparam logic [2:0]  SCC_CNT_MAX4 = 3'h3;
  localparam logic [2:0]  SCC_CNT_MAX8 = 3'h7;

  // x1 resonator range in kHz, xt1 nominal frequency in Hz
  localparam int unsigned SCC_X1_MIN_KHZ  = 1000;
  localparam int unsigned SCC_X1_MAX_KHZ  = 20000;
  localparam int unsigned SCC_XT1_NOM_HZ  = 32768;

  typedef enum logic [1:0] {
    SCC_PIN_PORT,
    SCC_PIN_RESONATOR,
    SCC_PIN_EXTERNAL
  } scc_pin_mode_t;

  typedef enum logic [1:0] {
    SCC_DRV_LOW_POWER,
    SCC_DRV_NORMAL,
    SCC_DRV_ULTRA_LOW,
    SCC_DRV_RESERVED
  } scc_drive_t;

  typedef enum logic [1:0] {
    SCC_CPU_ONCHIP,
    SCC_CPU_PLL,
    SCC_CPU_X1,
    SCC_CPU_SUB
  } scc_cpu_src_t;

  // oscillator pin and run configuration
  typedef struct packed {
    scc_pin_mode_t x1_mode;
    scc_pin_mode_t xt1_mode;
    scc_drive_t    xt1_drive;
    logic          x1_high_gain;
    logic          x1_osc_run;
    logic          xt1_osc_run;
    logic          fast_osc_run;
    logic          pll_run;
    logic          pll_mult_hi;
    logic          pll_ref_div2;
  } scc_osc_ctl_t;

  // low-speed oscillator run and routing
  typedef struct packed {
    logic run;
    logic to_wdt;
    logic to_rtc;
    logic to_itmr;
  } scc_lsosc_t;

  // register read-back
  typedef struct packed {
    logic [7:0] osc_mode_control;
    logic [7:0] osc_run_status_control;
    logic [7:0] system_clock_control;
    logic [7:0] pll_control;
    logic [7:0] main_source_control;
    logic [7:0] subsystem_supply_control;
  } scc_regs_t;

endpackage
`default_nettype wire

// ### scc_tick_div.sv
/*
  divides a one-cycle source tick by 2, 4 or 8.
  assumes the source tick is a single-cycle pulse synchronous to mclk.
*/
`timescale 1ns/1ns
`default_nettype none
module scc_tick_div #(
  parameter int unsigned CNT_W = 3
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // control
  input  wire logic [1:0]       ratio,
  input  wire logic             src_tick,
  // result
  output logic                  div_tick
);
  import scc_pkg::*;

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic [CNT_W-1:0] cnt_max;

  // terminal count from the ratio code; a reserved code never reaches here
  always_comb begin
    case (ratio)
      SCC_DIV2: cnt_max = CNT_W'(SCC_CNT_MAX2);
      SCC_DIV4: cnt_max = CNT_W'(SCC_CNT_MAX4);
      default:  cnt_max = CNT_W'(SCC_CNT_MAX8);
    endcase
    nxt_cnt  = cnt_ff;
    div_tick = 1'b0;
    if (src_tick) begin
      if (cnt_ff >= cnt_max) begin
        nxt_cnt  = '0;
        div_tick = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule
`default_nettype wire

// ### test_scc_clock_ctl.sv
/*
  self-checking bench for scc_clock_ctl with the oscillator model.
  assumes scc_pkg, scc_osc_model and the checker are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module test_scc_clock_ctl;
  import scc_pkg::*;
  localparam logic [47:0] MASKS = {SCC_MODE_MASK, SCC_RUN_MASK, SCC_SYS_MASK,
                                   SCC_PLL_MASK, SCC_MAIN_MASK, SCC_SUP_MASK};
  logic         mclk, rst, wdt, stby_run, standby, r, run;
  logic [7:0]   wr_data, wd;
  logic [5:0]   wr_stb;
  logic         fast_t, pll_t, x1_t, xt1_t, cpu_tick, usb_tick;
  scc_regs_t    regs_rd;
  scc_osc_ctl_t osc_ctl;
  scc_lsosc_t   lsosc;
  scc_cpu_src_t cpu_src;
  int           errors, n_compared, i;

  scc_clock_ctl DUT (.mclk(mclk), .rst(rst), .wr_data(wr_data), .wr_osc_mode(wr_stb[0]),
    .wr_osc_run(wr_stb[1]), .wr_sys_clk(wr_stb[2]), .wr_pll(wr_stb[3]),
    .wr_main_src(wr_stb[4]), .wr_supply(wr_stb[5]), .watchdog_run_option(wdt),
    .watchdog_standby_run(stby_run), .standby_active(standby), .fast_osc_tick(fast_t),
    .pll_tick(pll_t), .x1_tick(x1_t), .xt1_tick(xt1_t), .regs_rd(regs_rd), .osc_ctl(osc_ctl),
    .lsosc(lsosc), .cpu_src(cpu_src), .cpu_clk_tick(cpu_tick), .usb_src_tick(usb_tick));
  scc_osc_model u_osc (.mclk(mclk), .rst(rst), .osc_ctl(osc_ctl), .fast_osc_tick(fast_t),
    .pll_tick(pll_t), .x1_tick(x1_t), .xt1_tick(xt1_t));

  // 125 MHz clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // one register write; the strobe lasts a single cycle
  task automatic wr(input int k, input logic [7:0] d);
    @(negedge mclk);
    wr_stb[k] = 1'b1;
    wr_data   = d;
    @(negedge mclk);
    wr_stb    = 6'h00;
  endtask
  task automatic settle();
    repeat (2) @(negedge mclk);
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (12) @(negedge mclk);
    rst = 1'b0;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // cycles between the 2nd and 3rd cpu tick (usb tick if usb is set), so the phase has settled
  task automatic chk_gap(input int exp, input bit usb = 1'b0);
    int n, t, g;
    n = 0;
    t = 0;
    g = 0;
    while (t < 3 && n < 400) begin
      @(posedge mclk);
      #1;
      n++;
      g++;
      if ((usb ? usb_tick : cpu_tick) === 1'b1) begin
        t++;
        if (t < 3) g = 0;
      end
    end
    n_compared++;
    if (g != exp || t < 3) begin
      errors++;
      $display("MISMATCH t=%0t tick gap %0d exp %0d", $time, g, exp);
    end
  endtask
  function automatic logic [1:0] pin_exp(input logic [1:0] p);
    return (p == 2'h1) ? SCC_PIN_RESONATOR : (p == 2'h3) ? SCC_PIN_EXTERNAL : SCC_PIN_PORT;
  endfunction
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    errors = 0;
    n_compared = 0;
    {wr_stb, wr_data, wdt, stby_run, standby} = '0;
    do_reset();
    for (i = 0; i < 6; i++) chk(regs_rd[47-8*i -: 8], (i == 1) ? 8'hC0 : 8'h00, "reset reg");
    chk({7'h0, osc_ctl.fast_osc_run}, 8'h01, "fast osc after reset");
    chk_gap(4);
    $display("test reset done");
    // all ones, except that the main write is 04 (upper bits zero, divide code 10) and software does not
    // start the pll while the cpu already runs on the subclock
    for (i = 0; i < 6; i++) begin
      wd = (i == 3) ? 8'hFE : (i == 4) ? 8'h04 : 8'hFF;
      wr(i, wd);
      chk(regs_rd[47-8*i -: 8], wd & MASKS[47-8*i -: 8], "masked");
    end
    do_reset();
    chk(regs_rd.osc_run_status_control, 8'hC0, "second reset");
    $display("test reserved done");
    for (i = 0; i < 4; i++) begin
      // pin patterns 00, 01, 10, 11 on both oscillators, drive code and gain alongside
      wr(0, {i[1:0], i[1:0], 1'b0, i[1:0], i[0]});
      settle();
      chk({7'h0, osc_ctl.x1_high_gain}, {7'h0, i[0]}, "x1 gain");
      chk({6'h0, osc_ctl.x1_mode}, {6'h0, pin_exp(wr_data[7:6])}, "x1 pins");
      chk({6'h0, osc_ctl.xt1_mode}, {6'h0, pin_exp(wr_data[5:4])}, "xt1 pins");
      chk({6'h0, osc_ctl.xt1_drive}, {6'h0, i[1:0]}, "xt1 drive");
    end
    wr(0, 8'h00);
    wr(1, 8'hC1);
    settle();
    chk({7'h0, osc_ctl.fast_osc_run}, 8'h00, "fast halted");
    wr(1, 8'hC0);
    settle();
    chk({7'h0, osc_ctl.fast_osc_run}, 8'h01, "fast restarted");
    $display("test pins done");
    // pll started before the selector moves, so both sources run
    wr(3, 8'h01);
    settle();
    chk({5'h0, osc_ctl.pll_ref_div2, osc_ctl.pll_mult_hi, osc_ctl.pll_run}, 8'h01,
        "pll run");
    wr(4, 8'h03);
    chk_gap(12);
    chk({6'h0, cpu_src}, {6'h0, SCC_CPU_PLL}, "pll source");
    chk_gap(3, 1'b1);
    wr(4, 8'h05);
    chk_gap(24);
    wr(4, 8'h07);
    chk_gap(24);
    wr(4, 8'h00);
    chk_gap(4);
    chk_gap(2, 1'b1);
    wr(3, 8'h00);
    settle();
    chk({7'h0, osc_ctl.pll_run}, 8'h00, "pll stop");
    $display("test pll done");
    wr(0, 8'h40);
    wr(1, 8'h40);
    wr(2, 8'h10);
    settle();
    chk({6'h0, cpu_src}, {6'h0, SCC_CPU_X1}, "x1 source");
    chk_gap(5);
    wr(2, 8'h00);
    settle();
    chk({6'h0, cpu_src}, {6'h0, SCC_CPU_ONCHIP}, "selector source");
    wr(0, 8'h10);
    wr(1, 8'h80);
    settle();
    chk({7'h0, osc_ctl.xt1_osc_run}, 8'h01, "xt1 run");
    wr(2, 8'h40);
    chk_gap(7);
    chk({6'h0, cpu_src}, {6'h0, SCC_CPU_SUB}, "sub source");
    wr(2, 8'h00);
    $display("test sources done");
    for (i = 0; i < 16; i++) begin
      {wdt, r, stby_run, standby} = i[3:0];
      wr(5, {3'h0, r, 4'h0});
      settle();
      run = (wdt | r) & ~(wdt & ~r & ~stby_run & standby);
      chk({4'h0, lsosc}, {4'h0, run, run & wdt, run & r, run & r}, "low speed");
    end
    $display("test low speed done");
    give_verdict();
  end

  // hang guard, well past the few hundred cycles the tests need
  initial begin
    #400000;
    errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    give_verdict();
  end
endmodule

bind scc_clock_ctl scc_clock_ctl_checker u_chk (.mclk(mclk), .rst(rst), .wr_data(wr_data),
  .wr_osc_mode(wr_osc_mode), .wr_osc_run(wr_osc_run), .wr_pll(wr_pll),
  .watchdog_run_option(watchdog_run_option), .watchdog_standby_run(watchdog_standby_run),
  .standby_active(standby_active), .fast_osc_tick(fast_osc_tick), .pll_tick(pll_tick),
  .regs_rd(regs_rd), .osc_ctl(osc_ctl), .lsosc(lsosc), .cpu_src(cpu_src),
  .usb_src_tick(usb_src_tick));
`default_nettype wire
